// [rtl/mcumm_core.sv]
`timescale 1ns/1ps
module mcumm_core
    import mcumm_pkg::*;
(
    input logic hclk,
    input logic hresetn,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input logic fetch_req,
    input logic [12:0] fetch_addr,
    output logic fetch_valid_q,
    output logic [7:0] fetch_data_q,
    input logic vec_req,
    input logic [2:0] vec_src,
    output logic vec_done_q,
    output logic [12:0] start_pc_q,
    output logic memory_bank_enable_flag_q,
    output logic register_bank_enable_flag_q,
    input logic ref_req,
    input logic [5:0] ref_index,
    output logic ref_valid_q,
    output logic ref_err_q,
    output logic [12:0] ref_addr_q,
    output logic [15:0] ref_word_q,
    input logic select_memory_bank_op,
    input logic [3:0] smb_value,
    input logic select_register_bank_op,
    input logic [1:0] srb_value,
    output logic [3:0] mem_bank_q,
    output logic [1:0] active_reg_bank_q,
    input logic power_down_mode,
    input mcumm_dm_req_type dm_req,
    output mcumm_dm_rsp_type dm_rsp_q
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic [7:0] rom_mem [ROM_BYTES];
    logic ctrl_rom_we_q;
    logic [12:0] rom_ptr_q;
    logic ahb_wr_q;
    logic [7:0] ahb_waddr_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;
    logic ahb_sel;
    logic [31:0] rd_word;
    logic [31:0] status_word;
    logic [1:0] srb_q;
    mcumm_vec_state_type vs_q;
    logic [12:0] vaddr_q;
    logic [7:0] vhi_q;
    logic vec_accept;
    logic [12:0] ref_a;

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;

    // ------------------------------------------------------------
    // register bus slave, zero wait states
    // ------------------------------------------------------------
    assign ahb_sel = hsel && hready && htrans[1];
    assign status_word = {22'h0, vs_q != VS_IDLE, power_down_mode,
        mem_bank_q, active_reg_bank_q, register_bank_enable_flag_q,
        memory_bank_enable_flag_q};

    always_comb
    begin
        unique case (haddr[7:0])
            REG_CTRL: rd_word = {31'h0, ctrl_rom_we_q};
            REG_ROM_PTR: rd_word = {19'h0, rom_ptr_q};
            REG_ROM_DATA: rd_word = {24'h0, rom_mem[rom_ptr_q]};
            REG_STATUS: rd_word = status_word;
            default: rd_word = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ahb_wr_q <= 1'b0;
            ahb_waddr_q <= 8'h00;
            hrdata_q <= 32'h0;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
        else
        begin
            ahb_wr_q <= ahb_sel && hwrite && (hsize == AHB_SIZE_WORD);
            ahb_waddr_q <= haddr[7:0];
            if (ahb_sel && !hwrite)
            begin
                hrdata_q <= rd_word;
            end
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_rom_we_q <= CTRL_ROM_WE_RST;
        end
        else if (ahb_wr_q && ahb_waddr_q == REG_CTRL)
        begin
            ctrl_rom_we_q <= hwdata[CTRL_ROM_WE_BIT];
        end
    end

    // pointer steps after each data write taken while the ROM write enable is set, so a loader can stream bytes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rom_ptr_q <= 13'h0000;
        end
        else if (ahb_wr_q && ahb_waddr_q == REG_ROM_PTR)
        begin
            rom_ptr_q <= hwdata[12:0];
        end
        else if (ahb_wr_q && ahb_waddr_q == REG_ROM_DATA && ctrl_rom_we_q)
        begin
            rom_ptr_q <= rom_ptr_q + 13'h0001;
        end
    end

    // ------------------------------------------------------------
    // program store and fetch port
    // ------------------------------------------------------------
    always_ff @(posedge hclk)
    begin
        if (ahb_wr_q && ahb_waddr_q == REG_ROM_DATA && ctrl_rom_we_q)
        begin
            rom_mem[rom_ptr_q] <= hwdata[7:0];
        end
    end

    // vector and table bytes are fetched like any others
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fetch_valid_q <= 1'b0;
            fetch_data_q <= 8'h00;
        end
        else
        begin
            fetch_valid_q <= fetch_req;
            if (fetch_req)
            begin
                fetch_data_q <= rom_mem[fetch_addr];
            end
        end
    end

    a_fetch_any_addr: assert property (
        fetch_req |=> fetch_valid_q
            && fetch_data_q == rom_mem[$past(fetch_addr)])
        else $error("fetch byte or valid wrong");

    // ------------------------------------------------------------
    // vector loader
    // ------------------------------------------------------------
    // reset leaves the loader pointing at slot 0, so the reset vector
    // is taken without any request
    assign vec_accept = vec_req && vs_q == VS_IDLE && vec_src <= VEC_LAST;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            vs_q <= VS_HI;
            vaddr_q <= VEC_BASE;
            vhi_q <= 8'h00;
        end
        else
        begin
            unique case (vs_q)
                VS_IDLE:
                begin
                    if (vec_accept)
                    begin
                        vs_q <= VS_HI;
                        vaddr_q <= VEC_BASE + 13'({vec_src, 1'b0});
                    end
                end
                VS_HI:
                begin
                    vhi_q <= rom_mem[vaddr_q];
                    vs_q <= VS_LO;
                end
                VS_LO:
                begin
                    vs_q <= VS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            vec_done_q <= 1'b0;
            start_pc_q <= 13'h0000;
            memory_bank_enable_flag_q <= 1'b0;
            register_bank_enable_flag_q <= 1'b0;
        end
        else
        begin
            vec_done_q <= vs_q == VS_LO;
            if (vs_q == VS_LO)
            begin
                memory_bank_enable_flag_q <= vhi_q[VEC_MBE_BIT];
                register_bank_enable_flag_q <= vhi_q[VEC_RBE_BIT];
                // bit 5 dropped: only thirteen pc bits exist
                start_pc_q <= {vhi_q[VEC_PCH_MSB:0],
                    rom_mem[vaddr_q + 13'h0001]};
            end
        end
    end

    sequence s_vec_walk;
        (vs_q == VS_HI) ##1 (vs_q == VS_LO);
    endsequence

    a_vec_load_time: assert property (
        vec_accept |=> s_vec_walk ##1 vec_done_q)
        else $error("vector load not done three cycles after request");

    a_vec_slot_addr: assert property (
        vec_accept |=> vaddr_q == VEC_BASE + 13'({$past(vec_src), 1'b0}))
        else $error("vector slot address wrong");

    a_vec_fields: assert property (
        vec_done_q |-> start_pc_q[12:8] === $past(vhi_q[4:0])
            && memory_bank_enable_flag_q === $past(vhi_q[7])
            && register_bank_enable_flag_q === $past(vhi_q[6]))
        else $error("vector fields unpacked wrong");

    // ------------------------------------------------------------
    // look-up table reference
    // ------------------------------------------------------------
    assign ref_a = REF_BASE + 13'({ref_index, 1'b0});

    // entry returned big-end first: the byte at the even address on top
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ref_valid_q <= 1'b0;
            ref_err_q <= 1'b0;
            ref_addr_q <= REF_BASE;
            ref_word_q <= 16'h0000;
        end
        else
        begin
            ref_valid_q <= ref_req && ref_index <= REF_LAST;
            ref_err_q <= ref_req && ref_index > REF_LAST;
            if (ref_req && ref_index <= REF_LAST)
            begin
                ref_addr_q <= ref_a;
                ref_word_q <= {rom_mem[ref_a],
                    rom_mem[ref_a + 13'h0001]};
            end
        end
    end

    a_ref_entry_addr: assert property (
        ref_req && ref_index <= REF_LAST |=> ref_valid_q
            && ref_addr_q == REF_BASE + 13'({$past(ref_index), 1'b0}))
        else $error("table entry address wrong");

    // ------------------------------------------------------------
    // bank selection
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mem_bank_q <= BANK0;
        end
        else if (select_memory_bank_op && (smb_value == BANK0
            || smb_value == BANK1 || smb_value == BANK15))
        begin
            mem_bank_q <= smb_value;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            srb_q <= 2'h0;
            active_reg_bank_q <= 2'h0;
        end
        else
        begin
            if (select_register_bank_op)
            begin
                srb_q <= srb_value;
            end
            active_reg_bank_q <= register_bank_enable_flag_q
                ? srb_q : 2'h0;
        end
    end

    a_smb_select: assert property (
        select_memory_bank_op && smb_value == BANK15 |=> mem_bank_q == BANK15)
        else $error("bank select ignored");

    a_reg_bank_zero: assert property (
        !register_bank_enable_flag_q |=> active_reg_bank_q == 2'h0)
        else $error("register bank not forced to zero");

    // ------------------------------------------------------------
    // data memory
    // ------------------------------------------------------------
    logic dec_ok;
    logic dec_io;
    logic dec_bank1;
    logic [7:0] dm_mask;
    logic [7:0] dm_wbyte;
    logic [7:0] main_rd;
    logic [7:0] io_rd;
    logic p1_valid_q;
    logic p1_err_q;
    logic p1_io_q;
    logic p1_odd_q;
    logic [1:0] p1_bit_q;
    mcumm_width_type p1_width_q;
    logic [7:0] p1_byte;
    logic [3:0] p1_nib;
    logic [7:0] p1_rdata;

    always_comb
    begin
        dec_ok = 1'b1;
        dec_io = 1'b0;
        dec_bank1 = 1'b0;
        if (!memory_bank_enable_flag_q)
        begin
            dec_io = !dm_req.indirect && dm_req.addr >= DIRECT_LIMIT;
        end
        else if (mem_bank_q == BANK1)
        begin
            dec_bank1 = 1'b1;
        end
        else if (mem_bank_q == BANK15)
        begin
            dec_io = 1'b1;
            dec_ok = dm_req.addr >= DIRECT_LIMIT;
        end
        if (dm_req.width == MCUMM_W8 && (dm_req.addr[0]
            || (dec_bank1 && dm_req.addr >= LCD_FIRST)))
        begin
            dec_ok = 1'b0;
        end
    end

    always_comb
    begin
        unique case (dm_req.width)
            MCUMM_W1:
            begin
                dm_mask = 8'h01 << {dm_req.addr[0], dm_req.bit_sel};
                dm_wbyte = {8{dm_req.wdata[0]}};
            end
            MCUMM_W4:
            begin
                dm_mask = dm_req.addr[0] ? 8'hF0 : 8'h0F;
                dm_wbyte = {2{dm_req.wdata[3:0]}};
            end
            default:
            begin
                dm_mask = 8'hFF;
                dm_wbyte = dm_req.wdata;
            end
        endcase
    end

    // arrays carry no reset: power-on contents are unknown and a
    // reset taken in power-down keeps them
    mcumm_nibble_ram #(.NIBBLES(2 * DM_BANK_NIBBLES)) u_main_ram (
        .hclk(hclk),
        .addr({dec_bank1, dm_req.addr[7:1]}),
        .we(dm_req.req && dm_req.we && dec_ok && !dec_io),
        .mask(dm_mask),
        .wdata(dm_wbyte),
        .rdata(main_rd)
    );

    mcumm_nibble_ram #(.NIBBLES(IO_NIBBLES)) u_io_ram (
        .hclk(hclk),
        .addr(dm_req.addr[6:1]),
        .we(dm_req.req && dm_req.we && dec_ok && dec_io),
        .mask(dm_mask),
        .wdata(dm_wbyte),
        .rdata(io_rd)
    );

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            p1_valid_q <= 1'b0;
            p1_err_q <= 1'b0;
            p1_io_q <= 1'b0;
            p1_odd_q <= 1'b0;
            p1_bit_q <= 2'h0;
            p1_width_q <= MCUMM_W4;
        end
        else
        begin
            p1_valid_q <= dm_req.req;
            p1_err_q <= !dec_ok;
            p1_io_q <= dec_io;
            p1_odd_q <= dm_req.addr[0];
            p1_bit_q <= dm_req.bit_sel;
            p1_width_q <= dm_req.width;
        end
    end

    assign p1_byte = p1_io_q ? io_rd : main_rd;
    assign p1_nib = p1_odd_q ? p1_byte[7:4] : p1_byte[3:0];

    always_comb
    begin
        unique case (p1_width_q)
            MCUMM_W1: p1_rdata = {7'h00, p1_nib[p1_bit_q]};
            MCUMM_W4: p1_rdata = {4'h0, p1_nib};
            MCUMM_W8: p1_rdata = p1_byte;
            default: p1_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dm_rsp_q <= '0;
        end
        else
        begin
            dm_rsp_q.ack <= p1_valid_q;
            dm_rsp_q.err <= p1_valid_q && p1_err_q;
            dm_rsp_q.rdata <= p1_err_q ? 8'h00 : p1_rdata;
        end
    end

    a_dm_answer: assert property (
        dm_req.req |-> ##2 dm_rsp_q.ack)
        else $error("data access not answered in two cycles");

    a_lcd_no_byte: assert property (
        dm_req.req && dec_bank1 && dm_req.addr >= LCD_FIRST
            && dm_req.width == MCUMM_W8 |-> ##2 dm_rsp_q.err)
        else $error("byte access to display region accepted");

    a_emb_indirect: assert property (
        dm_req.req && !memory_bank_enable_flag_q && dm_req.indirect
            |-> !dec_io && !dec_bank1)
        else $error("indirect access left bank 0 with flag clear");
endmodule

// [include/mcumm_pkg.sv]
package mcumm_pkg;

    // ------------------------------------------------------------
    // program memory map
    // ------------------------------------------------------------
    localparam int ROM_BYTES = 8192;
    localparam int PC_W = 13;
    localparam logic [12:0] VEC_BASE = 13'h0000;
    localparam logic [2:0] VEC_LAST = 3'h6;
    localparam logic [12:0] REF_BASE = 13'h0020;
    localparam logic [5:0] REF_LAST = 6'h2F;
    localparam int VEC_MBE_BIT = 7;
    localparam int VEC_RBE_BIT = 6;
    localparam int VEC_PCH_MSB = 4;

    // ------------------------------------------------------------
    // data memory map
    // ------------------------------------------------------------
    localparam int DM_BANK_NIBBLES = 256;
    localparam int IO_NIBBLES = 128;
    localparam logic [3:0] BANK0 = 4'h0;
    localparam logic [3:0] BANK1 = 4'h1;
    localparam logic [3:0] BANK15 = 4'hF;
    localparam logic [7:0] DIRECT_LIMIT = 8'h80;
    localparam logic [7:0] LCD_FIRST = 8'hE6;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    localparam logic [2:0] AHB_SIZE_WORD = 3'h2;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ROM_PTR = 8'h04;
    localparam logic [7:0] REG_ROM_DATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam int CTRL_ROM_WE_BIT = 0;
    localparam logic CTRL_ROM_WE_RST = 1'b0;

    typedef enum logic [1:0] {
        MCUMM_W1,
        MCUMM_W4,
        MCUMM_W8
    } mcumm_width_type;

    typedef enum {VS_IDLE, VS_HI, VS_LO} mcumm_vec_state_type;

    typedef struct packed {
        logic req;
        logic we;
        logic indirect;
        mcumm_width_type width;
        logic [1:0] bit_sel;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mcumm_dm_req_type;

    typedef struct packed {
        logic ack;
        logic err;
        logic [7:0] rdata;
    } mcumm_dm_rsp_type;

endpackage

// [rtl/mcumm_nibble_ram.sv]
`timescale 1ns/1ps
module mcumm_nibble_ram #(
    parameter int NIBBLES = 256,
    localparam int AW = $clog2(NIBBLES / 2)
)
(
    input logic hclk,
    input logic [AW-1:0] addr,
    input logic we,
    input logic [7:0] mask,
    input logic [7:0] wdata,
    output logic [7:0] rdata
);
    // even nibble in the low half, odd nibble in the high half
    logic [7:0] mem [NIBBLES / 2];

    // no reset on purpose: contents survive any reset
    always_ff @(posedge hclk)
    begin
        if (we)
        begin
            mem[addr] <= (mem[addr] & ~mask) | (wdata & mask);
        end
        rdata <= mem[addr];
    end
endmodule

// [sim/mcumm_cpu_model.sv]
`timescale 1ns/1ps
module mcumm_cpu_model
    import mcumm_pkg::*;
(
    input logic hclk,
    output logic fetch_req,
    output logic [12:0] fetch_addr,
    input logic fetch_valid_q,
    output logic ref_req,
    output logic [5:0] ref_index,
    input logic ref_valid_q,
    input logic ref_err_q,
    output logic select_memory_bank_op,
    output logic [3:0] smb_value,
    output logic select_register_bank_op,
    output logic [1:0] srb_value,
    output mcumm_dm_req_type dm_req,
    input mcumm_dm_rsp_type dm_rsp_q
);
    // one request is open at a time, so any answer pulse ends the wait
    logic hit;
    assign hit = fetch_valid_q | ref_valid_q | ref_err_q
        | dm_rsp_q.ack | dm_rsp_q.err;

    initial
    begin
        fetch_req = 1'h0;
        fetch_addr = 13'h0;
        ref_req = 1'h0;
        ref_index = 6'h0;
        select_memory_bank_op = 1'h0;
        smb_value = 4'h0;
        select_register_bank_op = 1'h0;
        srb_value = 2'h0;
        dm_req = '0;
    end

    task automatic settle;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hit !== 1'h1 && n < 6);
    endtask

    task automatic fetch(input logic [12:0] a);
        @(posedge hclk);
        fetch_req <= 1'h1;
        fetch_addr <= a;
        @(posedge hclk);
        fetch_req <= 1'h0;
        settle();
    endtask

    // the index counts two-byte entries, never bytes
    task automatic refer(input logic [5:0] i);
        @(posedge hclk);
        ref_req <= 1'h1;
        ref_index <= i;
        @(posedge hclk);
        ref_req <= 1'h0;
        settle();
    endtask

    task automatic dm(input logic we, ind, input mcumm_width_type w,
                      input logic [1:0] b, input logic [7:0] a, d);
        @(posedge hclk);
        dm_req <= '{1'h1, we, ind, w, b, a, d};
        @(posedge hclk);
        dm_req.req <= 1'h0;
        settle();
    endtask

    task automatic sel(input logic m, input logic [3:0] mv,
                       input logic [1:0] rv);
        @(posedge hclk);
        select_memory_bank_op <= m;
        select_register_bank_op <= !m;
        smb_value <= mv;
        srb_value <= rv;
        @(posedge hclk);
        select_memory_bank_op <= 1'h0;
        select_register_bank_op <= 1'h0;
        repeat (3) @(posedge hclk);
    endtask
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench
    import mcumm_pkg::*;
;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h1;
    logic hready;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = AHB_SIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, fetch_req, fetch_valid_q, vec_done_q;
    logic memory_bank_enable_flag_q, register_bank_enable_flag_q;
    logic ref_req, ref_valid_q, ref_err_q;
    logic select_memory_bank_op, select_register_bank_op;
    logic vec_req = 1'h0;
    logic [2:0] vec_src = 3'h0;
    logic power_down_mode = 1'h0;
    logic [12:0] fetch_addr, start_pc_q, ref_addr_q;
    logic [7:0] fetch_data_q;
    logic [5:0] ref_index;
    logic [15:0] ref_word_q;
    logic [3:0] smb_value, mem_bank_q;
    logic [1:0] srb_value, active_reg_bank_q;
    mcumm_dm_req_type dm_req;
    mcumm_dm_rsp_type dm_rsp_q;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;

    assign hready = hreadyout;
    always #12.5 hclk = ~hclk;

    mcumm_core mcumm_core_i (.*);
    mcumm_cpu_model mcumm_cpu_model_i (.*);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic finish_test;
        if (mismatches == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [12:0] vpc(input logic [2:0] s);
        return {s, 10'h1A5};
    endfunction

    // bit 5 set on purpose: it must not leak into the start address
    function automatic logic [7:0] vb0(input logic [2:0] s);
        logic [12:0] p;
        p = vpc(s);
        return {s[0], s[1], 1'h1, p[12:8]};
    endfunction

    function automatic logic [7:0] tbyte(input logic [12:0] a);
        return a[7:0] ^ 8'hA5;
    endfunction

    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'h1);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'h1, a, d, r);
    endtask

    task automatic vec(input logic [2:0] s);
        int n;
        @(posedge hclk);
        vec_req <= 1'h1;
        vec_src <= s;
        @(posedge hclk);
        vec_req <= 1'h0;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (vec_done_q !== 1'h1 && n < 6);
    endtask

    task automatic dmc(input logic we, ind, input mcumm_width_type w,
                       input logic [1:0] b, input logic [7:0] a, d,
                       input logic [9:0] e);
        mcumm_cpu_model_i.dm(we, ind, w, b, a, d);
        chk({dm_rsp_q.ack, dm_rsp_q.err, we ? 8'h00 : dm_rsp_q.rdata}, e);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_rom;
        logic [31:0] r;
        ahb(1'h0, REG_CTRL, 32'h0, r);
        chk(r, 32'h0);
        chk({hresp, hreadyout}, 32'h1);
        ahb(1'h0, 8'h10, 32'h0, r);
        chk(r, 32'h0);
        wr(REG_CTRL, 32'h1);
        wr(REG_ROM_PTR, 32'h0);
        for (int s = 0; s < 7; s++)
        begin
            wr(REG_ROM_DATA, {24'h0, vb0(3'(s))});
            wr(REG_ROM_DATA, {24'h0, 8'(vpc(3'(s)))});
        end
        wr(REG_ROM_DATA, 32'h77);
        wr(REG_ROM_PTR, 32'h20);
        for (int a = 32; a < 128; a++)
            wr(REG_ROM_DATA, {24'h0, tbyte(13'(a))});
        wr(REG_ROM_PTR, 32'h1FFF);
        wr(REG_ROM_DATA, 32'hC3);
        wr(REG_CTRL, 32'h0);
        wr(REG_ROM_DATA, 32'hFF);
        wr(REG_ROM_PTR, 32'h0);
        ahb(1'h0, REG_ROM_DATA, 32'h0, r);
        chk(r, {24'h0, vb0(3'h0)});
        mcumm_cpu_model_i.fetch(13'h1FFF);
        chk({fetch_valid_q, fetch_data_q}, 9'h1C3);
        mcumm_cpu_model_i.fetch(13'h000E);
        chk({fetch_valid_q, fetch_data_q}, 9'h177);
        mcumm_cpu_model_i.fetch(13'h000C);
        chk({fetch_valid_q, fetch_data_q}, {1'h1, vb0(3'h6)});
    endtask

    // source 7 has no slot: previous start address and flags must hold
    task automatic t_vectors;
        logic [2:0] e;
        logic [31:0] got, want;
        for (int s = 0; s < 8; s++)
        begin
            e = (s == 7) ? 3'h6 : 3'(s);
            vec(3'(s));
            got = {vec_done_q, start_pc_q, memory_bank_enable_flag_q,
                   register_bank_enable_flag_q};
            want = {s != 7, vpc(e), e[0], e[1]};
            chk(got, want);
        end
    endtask

    task automatic t_table;
        logic [12:0] a;
        logic [31:0] got, want;
        for (int i = 0; i < 49; i++)
        begin
            a = 13'h20 + 13'(2 * i);
            mcumm_cpu_model_i.refer(6'(i));
            got = {ref_valid_q, ref_err_q, ref_addr_q, ref_word_q};
            want = {2'h2, a, tbyte(a), tbyte(a + 13'h1)};
            if (i == 48)
                chk(got[30:29], 2'h1);
            else
                chk(got, want);
        end
    endtask

    task automatic t_banks;
        logic [31:0] r;
        vec(3'h3);
        mcumm_cpu_model_i.sel(1'h0, 4'h0, 2'h2);
        ahb(1'h0, REG_STATUS, 32'h0, r);
        chk(active_reg_bank_q, 2'h2);
        chk(r & 32'h3FF, 32'h00B);
        vec(3'h1);
        repeat (3) @(posedge hclk);
        chk(active_reg_bank_q, 2'h0);
        mcumm_cpu_model_i.sel(1'h1, BANK0, 2'h0);
        dmc(1'h1, 1'h0, MCUMM_W4, 2'h0, 8'h90, 8'h04, 10'h200);
        mcumm_cpu_model_i.sel(1'h1, BANK15, 2'h0);
        dmc(1'h1, 1'h0, MCUMM_W4, 2'h0, 8'h90, 8'h09, 10'h200);
        mcumm_cpu_model_i.sel(1'h1, 4'h7, 2'h0);
        chk(mem_bank_q, BANK15);
        dmc(1'h0, 1'h0, MCUMM_W4, 2'h0, 8'h10, 8'h00, 10'h300);
        vec(3'h0);
        dmc(1'h0, 1'h0, MCUMM_W4, 2'h0, 8'h90, 8'h00, 10'h209);
        dmc(1'h0, 1'h1, MCUMM_W4, 2'h0, 8'h90, 8'h00, 10'h204);
    endtask

    task automatic t_access;
        vec(3'h1);
        mcumm_cpu_model_i.sel(1'h1, BANK1, 2'h0);
        dmc(1'h1, 1'h0, MCUMM_W4, 2'h0, 8'hFF, 8'h0A, 10'h200);
        mcumm_cpu_model_i.sel(1'h1, BANK0, 2'h0);
        dmc(1'h1, 1'h0, MCUMM_W4, 2'h0, 8'hFF, 8'h05, 10'h200);
        mcumm_cpu_model_i.sel(1'h1, BANK1, 2'h0);
        dmc(1'h0, 1'h0, MCUMM_W4, 2'h0, 8'hFF, 8'h00, 10'h20A);
        dmc(1'h1, 1'h0, MCUMM_W8, 2'h0, 8'h20, 8'hC3, 10'h200);
        dmc(1'h0, 1'h0, MCUMM_W8, 2'h0, 8'h20, 8'h00, 10'h2C3);
        dmc(1'h0, 1'h0, MCUMM_W4, 2'h0, 8'h21, 8'h00, 10'h20C);
        dmc(1'h1, 1'h0, MCUMM_W8, 2'h0, 8'h21, 8'h55, 10'h300);
        dmc(1'h1, 1'h0, MCUMM_W8, 2'h0, 8'hE6, 8'h55, 10'h300);
        dmc(1'h1, 1'h0, MCUMM_W4, 2'h0, 8'hE6, 8'h06, 10'h200);
        dmc(1'h1, 1'h0, MCUMM_W1, 2'h3, 8'hE6, 8'h01, 10'h200);
        dmc(1'h0, 1'h0, MCUMM_W4, 2'h0, 8'hE6, 8'h00, 10'h20E);
        dmc(1'h0, 1'h0, MCUMM_W1, 2'h0, 8'hE6, 8'h00, 10'h200);
        dmc(1'h0, 1'h0, MCUMM_W1, 2'h1, 8'hE6, 8'h00, 10'h201);
    endtask

    // a reset taken in power-down must not disturb the data store
    task automatic t_power_down;
        logic [31:0] r;
        @(posedge hclk);
        power_down_mode <= 1'h1;
        ahb(1'h0, REG_STATUS, 32'h0, r);
        chk(r & 32'h100, 32'h100);
        hresetn <= 1'h0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'h1;
        repeat (5) @(posedge hclk);
        power_down_mode <= 1'h0;
        chk(mem_bank_q, BANK0);
        dmc(1'h0, 1'h1, MCUMM_W4, 2'h0, 8'h90, 8'h00, 10'h204);
    endtask

    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'h1;
        repeat (5) @(posedge hclk);
        t_rom();
        t_vectors();
        t_table();
        t_banks();
        t_access();
        t_power_down();
        finish_test();
    end
endmodule
